// [dio_pkg.sv]
`default_nettype none
package dio_pkg;
   localparam int LINE_COUNT = 8;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   localparam logic [7:0] WORD_ZERO = 8'h00;
   localparam int SYNC_STAGES = 2;
   localparam int PIN_GND = 5;
   typedef logic [LINE_COUNT-1:0] word_t;
   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_DIR,
      CMD_LEVEL,
      CMD_QUERY
   } cmd_t;
endpackage : dio_pkg
`default_nettype wire

// [pin_if.sv]
`default_nettype none
interface pin_if;
   import dio_pkg::*;
   word_t raw;
   word_t synced;
   modport src (output raw, input synced);
   modport sync (input raw, output synced);
endinterface : pin_if
`default_nettype wire

// [pin_sync.sv]
`default_nettype none
module pin_sync
   import dio_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   pin_if.sync pins
);
   typedef struct packed {
      word_t meta;
      word_t stable;
   } sync_state_t;
   sync_state_t st_r;
   sync_state_t st_nxt;

   // The first stage feeds only the second stage.
   always_comb begin
      st_nxt = st_r;
      if (ce_in) begin
         st_nxt.meta = pins.raw;
         st_nxt.stable = st_r.meta;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pins.synced = st_r.stable;
endmodule : pin_sync
`default_nettype wire

// [dio_port.sv]
`default_nettype none
module dio_port
   import dio_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Command port from the remote command decoder.
   input wire logic dir_we_in,
   input wire logic level_we_in,
   input wire logic query_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] state_out,
   output logic state_valid_out,
   output logic [7:0] dir_out,
   // Connector lines, bit n as in the word layout.
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_out
);
   typedef struct packed {
      word_t dir;
      word_t level;
      word_t pin_drive;
      word_t pin_en;
      word_t state;
      logic state_valid;
   } port_state_t;

   port_state_t st_r;
   port_state_t st_nxt;
   word_t sampled;
   cmd_t cmd;

   pin_if pins_i ();
   assign pins_i.raw = pin_in;
   assign sampled = pins_i.synced;

   pin_sync sync_u (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .pins(pins_i.sync)
   );

   // Direction writes take priority when several strobes coincide.
   function automatic cmd_t decode(input logic d, input logic l, input logic q);
      cmd_t c;
      c = CMD_NONE;
      if (d) begin
         c = CMD_DIR;
      end else if (l) begin
         c = CMD_LEVEL;
      end else if (q) begin
         c = CMD_QUERY;
      end
      return c;
   endfunction : decode

   assign cmd = decode(dir_we_in, level_we_in, query_in);

   // Drive and enable are taken from the next-state words, so a write reaches the
   // pins on the same edge as the stored word, with no stale cycle between them.
   always_comb begin
      st_nxt = st_r;
      if (ce_in) begin
         st_nxt.state_valid = 1'b0;
         unique case (cmd)
            CMD_DIR: begin
               st_nxt.dir = wdata_in;
            end
            CMD_LEVEL: begin
               st_nxt.level = wdata_in;
            end
            CMD_QUERY: begin
               st_nxt.state = sampled & ~st_r.dir;
               st_nxt.state_valid = 1'b1;
            end
            CMD_NONE: begin
            end
         endcase
         st_nxt.pin_en = st_nxt.dir;
         st_nxt.pin_drive = st_nxt.level & st_nxt.dir;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r.dir <= DIR_RESET;
         st_r.level <= LEVEL_RESET;
         st_r.pin_drive <= WORD_ZERO;
         st_r.pin_en <= WORD_ZERO;
         st_r.state <= WORD_ZERO;
         st_r.state_valid <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // The word layout is identity-mapped; the ground position (PIN_GND, bit 5) still has a port bit.
   assign pin_out = st_r.pin_drive;
   assign pin_oe_out = st_r.pin_en;
   assign state_out = st_r.state;
   assign state_valid_out = st_r.state_valid;
   assign dir_out = st_r.dir;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // Only the strobe that wins the priority decode counts as a command.
   sequence dir_write_s;
      ce_in && dir_we_in;
   endsequence

   sequence level_write_s;
      ce_in && level_we_in && !dir_we_in;
   endsequence

   sequence query_only_s;
      ce_in && query_in && !dir_we_in && !level_we_in;
   endsequence

   // The synchroniser only tracks the connector after two enabled edges
   // out of reset, so the pin path check waits for both.
   sequence sync_run_s;
      rst_b_in && ce_in ##1 ce_in;
   endsequence

   dir_store_a: assert property (dir_write_s |=> dir_out == $past(wdata_in))
      else $error("direction word not stored");

   oe_follow_a: assert property (dir_write_s |=> pin_oe_out == $past(wdata_in))
      else $error("output enables do not follow direction");

   level_drive_a: assert property (level_write_s |=>
      pin_out == ($past(wdata_in) & dir_out))
      else $error("output level not driven");

   input_ignore_a: assert property (pin_out == (pin_out & pin_oe_out))
      else $error("input line driven");

   out_zero_a: assert property (state_valid_out |-> (state_out & dir_out) == 8'h00)
      else $error("output line reported nonzero");

   query_pulse_a: assert property (query_only_s |=> state_valid_out &&
      state_out == ($past(sampled) & ~$past(dir_out)))
      else $error("state query answer wrong");

   query_fill_a: assert property (ce_in && !(query_in && !dir_we_in && !level_we_in) |=>
      !state_valid_out)
      else $error("state valid held too long");

   word_map_a: assert property (pin_oe_out == dir_out)
      else $error("output enables differ from direction");

   reset_val_a: assert property ($rose(rst_b_in) |-> dir_out == 8'h00 && pin_out == 8'h00)
      else $error("reset state wrong");

   freeze_a: assert property (!ce_in |=> $stable(dir_out) && $stable(pin_out))
      else $error("state changed while disabled");

   hold_all_a: assert property (!ce_in |=>
      $stable(state_out) && $stable(state_valid_out) && $stable(pin_oe_out))
      else $error("query state changed while disabled");

   dir_hold_a: assert property (ce_in && !dir_we_in |=> $stable(dir_out))
      else $error("direction word changed without a write");

   level_hold_a: assert property (ce_in && !dir_we_in && !level_we_in |=>
      $stable(pin_out))
      else $error("output level changed without a write");

   state_hold_a: assert property (!(ce_in && query_in && !dir_we_in && !level_we_in) |=>
      $stable(state_out))
      else $error("state word changed without a query");

   drive_mask_a: assert property (dir_write_s |=>
      (pin_out & ~$past(wdata_in)) == 8'h00)
      else $error("new input line still driven");

   strobe_prio_a: assert property (ce_in && (dir_we_in || level_we_in) |=>
      !state_valid_out)
      else $error("query answered beside a write");

   reset_idle_a: assert property ($rose(rst_b_in) |->
      state_out == 8'h00 && !state_valid_out && pin_oe_out == 8'h00)
      else $error("query state not idle after reset");

   sync_delay_a: assert property (sync_run_s |=> sampled == $past(pin_in, 2))
      else $error("pin synchroniser delay wrong");

   // Each line is checked on its own so that a failure points at one bit.
   for (genvar i = 0; i < LINE_COUNT; i++) begin : g_line
      line_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
         !pin_oe_out[i] |-> !pin_out[i])
         else $error("input line driven high");

      line_report_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
         state_valid_out && dir_out[i] |-> !state_out[i])
         else $error("output line reported high");

      line_level_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
         ce_in && level_we_in && !dir_we_in && dir_out[i] |=>
         pin_out[i] == $past(wdata_in[i]))
         else $error("output line level wrong");

      line_input_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
         ce_in && query_in && !dir_we_in && !level_we_in && !dir_out[i] |=>
         state_out[i] == $past(sampled[i]))
         else $error("input line reported wrong");
   end
endmodule : dio_port
`default_nettype wire

// [dio_equip.sv]
`default_nettype none
module dio_equip
   import dio_pkg::*;
(
   // Equipment drive and port drive.
   input wire logic [7:0] drive_in,
   input wire logic [7:0] pin_out_in,
   input wire logic [7:0] pin_oe_in,
   // Resolved line levels.
   output logic [7:0] wire_out
);
   // A driven line shows the port level; the rest show the equipment level.
   assign wire_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_in);
endmodule : dio_equip
`default_nettype wire

// [tb_dio_port.sv]
`default_nettype none
module tb_dio_port;
   timeunit 1ns;
   timeprecision 1ps;
   import dio_pkg::*;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic ce_in = 1'b1;
   logic dir_we_in = 1'b0;
   logic level_we_in = 1'b0;
   logic query_in = 1'b0;
   logic state_valid_out;
   word_t wdata_in = 8'h00;
   word_t drive = 8'h00;
   word_t pin_in, state_out, dir_out, pin_out, pin_oe_out;
   int fail_count = 0;
   int samples_checked = 0;
   dio_port DUT (.clk_in, .rst_b_in, .ce_in, .dir_we_in, .level_we_in, .query_in,
      .wdata_in, .state_out, .state_valid_out, .dir_out, .pin_in, .pin_out, .pin_oe_out);
   dio_equip EQ (.drive_in(drive), .pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
      .wire_out(pin_in));
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic print_verdict;
      $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input word_t got, input word_t exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input logic d, input logic l, input logic q, input word_t w);
      @(posedge clk_in);
      dir_we_in <= d;
      level_we_in <= l;
      query_in <= q;
      wdata_in <= w;
      @(posedge clk_in);
      dir_we_in <= 1'b0;
      level_we_in <= 1'b0;
      query_in <= 1'b0;
      #1;
   endtask : cmd
   // Sync stages plus margin before the query can see a new level.
   task automatic read_inputs(input word_t lv, input word_t exp);
      @(posedge clk_in);
      drive <= lv;
      repeat (4) @(posedge clk_in);
      cmd(1'b0, 1'b0, 1'b1, 8'h00);
      chk(state_out, exp);
      chk({7'h00, state_valid_out}, 8'h01);
      @(posedge clk_in);
      #1;
      chk({7'h00, state_valid_out}, 8'h00);
   endtask : read_inputs
   task automatic t_reset;
      chk(dir_out, 8'h00);
      chk(pin_oe_out, 8'h00);
      chk(pin_out, 8'h00);
      chk(state_out, 8'h00);
      chk({7'h00, state_valid_out}, 8'h00);
   endtask : t_reset
   task automatic t_outputs;
      cmd(1'b1, 1'b0, 1'b0, 8'h54);
      chk(pin_oe_out, 8'h54);
      cmd(1'b0, 1'b1, 1'b0, 8'h44);
      chk(pin_out, 8'h44);
      cmd(1'b0, 1'b1, 1'b0, 8'hff);
      chk(pin_out, 8'h54);
      read_inputs(8'hff, 8'hab);
   endtask : t_outputs
   task automatic t_prio_ce;
      cmd(1'b1, 1'b0, 1'b1, 8'hd4);
      chk(dir_out, 8'hd4);
      chk({7'h00, state_valid_out}, 8'h00);
      cmd(1'b0, 1'b1, 1'b1, 8'h80);
      chk(pin_out, 8'h80);
      chk({7'h00, state_valid_out}, 8'h00);
      @(posedge clk_in);
      ce_in <= 1'b0;
      cmd(1'b1, 1'b0, 1'b0, 8'h0f);
      chk(dir_out, 8'hd4);
      @(posedge clk_in);
      ce_in <= 1'b1;
      rst_b_in <= 1'b0;
      @(posedge clk_in);
      #1;
      t_reset();
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      read_inputs(8'h5a, 8'h5a);
   endtask : t_prio_ce
   initial begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      #1;
      t_reset();
      read_inputs(8'h03, 8'h03);
      read_inputs(8'ha5, 8'ha5);
      t_outputs();
      t_prio_ce();
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk_in);
      fail_count++;
      print_verdict();
   end
endmodule : tb_dio_port
`default_nettype wire
